// ---- logic/pps_regs.sv ----
// paged port status, identification and maker page registers behind an axi4-lite slave
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/100ps
module pps_regs
   import pps_pkg::*;
#(
   parameter int NPORTS = 3,
   parameter logic [23:0] MAKER_ID = 24'h00_0001, // arbitrary neutral value
   parameter logic [23:0] PART_ID = 24'h00_0002 // arbitrary neutral value
)
(
   input wire logic aclk, // 125 mhz clock
   input wire logic aresetn, // synchronous reset, active low
   input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
   input wire logic [2:0] s_axi_awprot, // write protection, unused
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [DATA_W-1:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte lanes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
   input wire logic [2:0] s_axi_arprot, // read protection, unused
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [DATA_W-1:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic [NPORTS-1:0] codeword_error, // pulse: invalid codeword received
   input wire logic [NPORTS-1:0] remote_error_read, // pulse: counter read by remote packet
   input wire logic [NPORTS-1:0] loop_disable_enter, // pulse: port put in loop-disable
   input wire logic bus_reset, // pulse: bus reset
   input wire logic [NPORTS-1:0] port_disconnect, // pulse: port became disconnected
   input wire logic [NPORTS-1:0] port_in_standby, // level: port in standby state
   input wire logic [NPORTS-1:0] port_disabled, // level: port disabled
   input wire logic [NPORTS-1:0] raw_attached, // level: attached status from port
   input wire logic [NPORTS-1:0] raw_receive_good, // level: receive-good status from port
   output logic [NPORTS-1:0] attached_flag, // attached status after deep shutoff
   output logic [NPORTS-1:0] receive_good_flag, // receive-good after deep shutoff
   output logic [NPORTS-1:0] ac_track_enable, // ac connectivity tracking allowed
   output logic [NPORTS-1:0] tone_enable, // connectivity tones allowed
   output logic phy_hard_reset, // high while the soft hard reset acts
   output logic irq // level interrupt
);

   // ==========================================================
   // internal state
   logic [2:0] page_select;
   logic [7:0] err_count [NPORTS];
   logic [NPORTS-1:0] loop_blocked;
   logic [NPORTS-1:0] deep_shutoff;
   logic [2*NPORTS-1:0] irq_status;
   logic [2*NPORTS-1:0] irq_enable;
   logic [7:0] soft_cnt;
   logic [DATA_W-1:0] rdata_q;
   logic [1:0] rresp_q;
   logic rvalid_q;
   logic bvalid_q;
   logic [1:0] bresp_q;

   // the soft reset clears the phy state but not the bus slave, so the
   // response to the write that started it still completes
   wire phy_rst_n = aresetn & (soft_cnt == 8'h00);

   // ==========================================================
   // bus handshake
   wire wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
   wire rd_go = s_axi_arvalid & ~rvalid_q;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = rd_go;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   wire [IDX_W-1:0] wr_idx = s_axi_awaddr[ADDR_W-1:2];
   wire [IDX_W-1:0] rd_idx = s_axi_araddr[ADDR_W-1:2];
   wire [IDX_W-1:0] wr_port_off = wr_idx - IDX_PORT_BASE;
   wire [IDX_W-1:0] rd_port_off = rd_idx - IDX_PORT_BASE;
   wire wr_port_hit = (wr_idx >= IDX_PORT_BASE) && (wr_port_off < IDX_W'(NPORTS));
   wire rd_port_hit = (rd_idx >= IDX_PORT_BASE) && (rd_port_off < IDX_W'(NPORTS));
   wire wr_paged = (wr_idx >= IDX_PAGED_LO) && (wr_idx <= IDX_PAGED_HI);
   wire rd_paged = (rd_idx >= IDX_PAGED_LO) && (rd_idx <= IDX_PAGED_HI);

   // ==========================================================
   // write decode
   wire wr_lane0 = wr_go & s_axi_wstrb[0];
   wire wr_lane1 = wr_go & s_axi_wstrb[1];
   wire wr_page_sel = wr_lane0 && (wr_idx == IDX_PAGE_SELECT);
   wire wr_irq_en = wr_lane0 && (wr_idx == IDX_IRQ_ENABLE);
   wire wr_irq_clr = wr_lane0 && (wr_idx == IDX_IRQ_CLEAR);
   wire wr_soft_rst = wr_lane0 && (wr_idx == IDX_SOFT_RESET) && (page_select == PAGE_MAKER)
      && s_axi_wdata[SOFT_RESET_BIT];
   wire wr_known = (wr_idx == IDX_PAGE_SELECT) || wr_paged || wr_port_hit
      || (wr_idx == IDX_IRQ_STATUS) || (wr_idx == IDX_IRQ_ENABLE) || (wr_idx == IDX_IRQ_CLEAR);
   // all other paged writes land on read-only or reserved places and are dropped

   // ==========================================================
   // read decode and paged selection
   wire [23:0] maker_identifier = MAKER_ID;
   wire [23:0] part_identifier = PART_ID;
   wire [7:0] ident_byte =
      (rd_idx == IDX_COMPLIANCE) ? COMPLIANCE_VALUE :
      (rd_idx == IDX_MAKER_HI) ? maker_identifier[23:16] :
      (rd_idx == IDX_MAKER_MID) ? maker_identifier[15:8] :
      (rd_idx == IDX_MAKER_LO) ? maker_identifier[7:0] :
      (rd_idx == IDX_PART_HI) ? part_identifier[23:16] :
      (rd_idx == IDX_PART_MID) ? part_identifier[15:8] :
      (rd_idx == IDX_PART_LO) ? part_identifier[7:0] :
      8'h00; // reserved
   // maker page: soft reset bit reads zero and test places read zero
   wire [7:0] maker_byte = 8'h00;
   wire [7:0] paged_byte =
      (page_select == PAGE_IDENT) ? ident_byte :
      (page_select == PAGE_MAKER) ? maker_byte :
      8'h00;

   logic [DATA_W-1:0] port_word [NPORTS];
   wire [DATA_W-1:0] irq_status_word = {{(DATA_W-2*NPORTS){1'b0}}, irq_status};
   wire [DATA_W-1:0] irq_enable_word = {{(DATA_W-2*NPORTS){1'b0}}, irq_enable};
   wire [DATA_W-1:0] rd_word;
   wire rd_known;
   assign rd_word =
      (rd_idx == IDX_PAGE_SELECT) ? {29'h0000_0000, page_select} :
      rd_paged ? {24'h00_0000, paged_byte} :
      rd_port_hit ? port_word[rd_port_off[1:0]] :
      (rd_idx == IDX_IRQ_STATUS) ? irq_status_word :
      (rd_idx == IDX_IRQ_ENABLE) ? irq_enable_word :
      32'h0000_0000;
   assign rd_known = (rd_idx == IDX_PAGE_SELECT) || rd_paged || rd_port_hit
      || (rd_idx == IDX_IRQ_STATUS) || (rd_idx == IDX_IRQ_ENABLE);

   // ==========================================================
   // bus response registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end
      else if (wr_go)
      begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
         bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end
      else if (rd_go)
      begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_word;
         rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
         rvalid_q <= 1'b0;
      end
   end

   // ==========================================================
   // soft hard reset: pulse of fixed length, on a soft reset bit write in the maker page only
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         soft_cnt <= 8'h00;
      else if (wr_soft_rst)
         soft_cnt <= SOFT_RESET_CNT;
      else if (soft_cnt != 8'h00)
         soft_cnt <= soft_cnt - 8'h01;
   end
   assign phy_hard_reset = (soft_cnt != 8'h00);

   // ==========================================================
   // page select
   always_ff @(posedge aclk)
   begin
      if (!phy_rst_n)
         page_select <= PAGE_RESET;
      else if (wr_page_sel)
         page_select <= s_axi_wdata[2:0];
   end

   // ==========================================================
   // per-port status
   logic [NPORTS-1:0] sat_event;
   logic [NPORTS-1:0] loop_event;

   genvar p;
   generate
      for (p = 0; p < NPORTS; p++)
      begin : g_port
         wire rd_this = rd_go && rd_port_hit && (rd_port_off == IDX_W'(p));
         wire wr_this = wr_lane1 && wr_port_hit && (wr_port_off == IDX_W'(p));
         wire cnt_clear = rd_this | remote_error_read[p];
         wire cnt_full = (err_count[p] == ERR_COUNT_MAX);
         wire [7:0] cnt_step = cnt_full ? err_count[p] : err_count[p] + 8'h01;
         wire [7:0] next_count = cnt_clear ? {7'h00, codeword_error[p]} :
            (codeword_error[p] ? cnt_step : err_count[p]);
         wire deep_active = deep_shutoff[p] & port_disabled[p];

         always_ff @(posedge aclk)
         begin
            if (!phy_rst_n)
               err_count[p] <= 8'h00;
            else
               err_count[p] <= next_count;
         end

         // a disconnect or bus reset in the same cycle as entry leaves it clear
         always_ff @(posedge aclk)
         begin
            if (!phy_rst_n)
               loop_blocked[p] <= 1'b0;
            else if (bus_reset | port_disconnect[p])
               loop_blocked[p] <= 1'b0;
            else if (loop_disable_enter[p])
               loop_blocked[p] <= 1'b1;
         end

         always_ff @(posedge aclk)
         begin
            if (!phy_rst_n)
               deep_shutoff[p] <= 1'b0;
            else if (wr_this)
               deep_shutoff[p] <= s_axi_wdata[PORT_DEEP_OFF_BIT];
         end

         assign sat_event[p] = codeword_error[p] & ~cnt_clear & (cnt_step == ERR_COUNT_MAX)
            & ~cnt_full;
         assign loop_event[p] = loop_disable_enter[p] & ~bus_reset & ~port_disconnect[p]
            & ~loop_blocked[p];
         assign attached_flag[p] = raw_attached[p] & ~deep_active;
         assign receive_good_flag[p] = raw_receive_good[p] & ~deep_active;
         assign ac_track_enable[p] = ~deep_active;
         assign tone_enable[p] = ~deep_active;
         assign port_word[p] = {21'h00_0000, deep_shutoff[p], port_in_standby[p],
            loop_blocked[p], err_count[p]};
      end
   endgenerate

   // ==========================================================
   // interrupts: sticky status, set wins over clear
   wire [2*NPORTS-1:0] irq_set = {loop_event, sat_event};
   wire [2*NPORTS-1:0] irq_clr = wr_irq_clr ? s_axi_wdata[2*NPORTS-1:0] : '0;

   always_ff @(posedge aclk)
   begin
      if (!phy_rst_n)
         irq_status <= '0;
      else
         irq_status <= irq_set | (irq_status & ~irq_clr);
   end

   always_ff @(posedge aclk)
   begin
      if (!phy_rst_n)
         irq_enable <= '0;
      else if (wr_irq_en)
         irq_enable <= s_axi_wdata[2*NPORTS-1:0];
   end

   assign irq = |(irq_status & irq_enable);

endmodule // pps_regs

// ---- logic/pps_pkg.sv ----
// constants and register map of the paged status and identification register bank
package pps_pkg;
   // ==========================================================
   // bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int IDX_W = 6;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ==========================================================
   // register indices, byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_PAGE_SELECT = 6'h07;
   localparam logic [IDX_W-1:0] IDX_COMPLIANCE = 6'h08;
   localparam logic [IDX_W-1:0] IDX_MAKER_HI = 6'h0a;
   localparam logic [IDX_W-1:0] IDX_MAKER_MID = 6'h0b;
   localparam logic [IDX_W-1:0] IDX_MAKER_LO = 6'h0c;
   localparam logic [IDX_W-1:0] IDX_PART_HI = 6'h0d;
   localparam logic [IDX_W-1:0] IDX_PART_MID = 6'h0e;
   localparam logic [IDX_W-1:0] IDX_SOFT_RESET = 6'h0e;
   localparam logic [IDX_W-1:0] IDX_PART_LO = 6'h0f;
   localparam logic [IDX_W-1:0] IDX_PORT_BASE = 6'h10;
   localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 6'h14;
   localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 6'h15;
   localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR = 6'h16;
   localparam logic [IDX_W-1:0] IDX_PAGED_LO = 6'h08;
   localparam logic [IDX_W-1:0] IDX_PAGED_HI = 6'h0f;

   // ==========================================================
   // page numbers and fixed values
   localparam logic [2:0] PAGE_IDENT = 3'h1;
   localparam logic [2:0] PAGE_MAKER = 3'h7;
   localparam logic [2:0] PAGE_RESET = 3'h0;
   localparam logic [7:0] COMPLIANCE_VALUE = 8'h02;
   localparam logic [7:0] ERR_COUNT_MAX = 8'hff;
   localparam int SOFT_RESET_BIT = 0;

   // ==========================================================
   // per-port status word layout
   localparam int PORT_ERR_LSB = 0;
   localparam int PORT_LOOP_BIT = 8;
   localparam int PORT_STANDBY_BIT = 9;
   localparam int PORT_DEEP_OFF_BIT = 10;

   // ==========================================================
   // timing: soft hard-reset pulse length
   localparam int CLK_PERIOD_PS = 8000;
   localparam int SOFT_RESET_NS = 80;
   localparam int SOFT_RESET_CYC = (SOFT_RESET_NS * 1000) / CLK_PERIOD_PS;
   localparam logic [7:0] SOFT_RESET_CNT = 8'(SOFT_RESET_CYC);
endpackage

// ---- tb/pps_regs_props.sv ----
// concurrent checks on the paged register bank ports
`timescale 1ns/100ps
module pps_regs_props
   import pps_pkg::*;
#(
   parameter int NPORTS = 3
)
(
   input wire logic aclk, // clock
   input wire logic aresetn, // reset
   input wire logic s_axi_awvalid, // aw valid
   input wire logic s_axi_awready, // aw ready
   input wire logic s_axi_wvalid, // w valid
   input wire logic s_axi_wready, // w ready
   input wire logic s_axi_bvalid, // b valid
   input wire logic s_axi_arvalid, // ar valid
   input wire logic s_axi_arready, // ar ready
   input wire logic s_axi_rvalid, // r valid
   input wire logic [DATA_W-1:0] s_axi_rdata, // r data
   input wire logic s_axi_rready, // r ready
   input wire logic [NPORTS-1:0] port_disabled, // disabled
   input wire logic [NPORTS-1:0] raw_attached, // raw attached
   input wire logic [NPORTS-1:0] raw_receive_good, // raw rx good
   input wire logic [NPORTS-1:0] attached_flag, // attached out
   input wire logic [NPORTS-1:0] receive_good_flag, // rx good out
   input wire logic [NPORTS-1:0] ac_track_enable, // ac tracking
   input wire logic [NPORTS-1:0] tone_enable, // tones
   input wire logic phy_hard_reset // soft hard reset
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========================================================
   // bus timing
   wr_resp_a: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("write response missing");
   rd_resp_a: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data missing");
   rd_hold_a: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   // ==========================================================
   // port gating and soft reset
   hard_len_a: assert property (
      $rose(phy_hard_reset) |-> phy_hard_reset[*8] ##1 phy_hard_reset ##1 phy_hard_reset
      ##1 !phy_hard_reset) else $error("hard reset length wrong");
   gate_idle_a: assert property (
      (~port_disabled & ~tone_enable) == '0) else $error("shutoff acts on enabled port");
   att_gate_a: assert property (
      attached_flag == (raw_attached & ac_track_enable)) else $error("attached gating wrong");
   receive_good_flag_gate_a: assert property (
      receive_good_flag == (raw_receive_good & tone_enable)) else $error("rx good gating wrong");
   tone_track_a: assert property (
      tone_enable == ac_track_enable) else $error("tones and tracking disagree");
   cover property ($rose(phy_hard_reset));
   cover property (s_axi_rvalid && s_axi_rready);
   cover property (port_disabled[0] && !tone_enable[0]);
endmodule // pps_regs_props

bind pps_regs pps_regs_props #(.NPORTS(NPORTS)) props_u (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .s_axi_rready(s_axi_rready),
   .port_disabled(port_disabled), .raw_attached(raw_attached),
   .raw_receive_good(raw_receive_good), .attached_flag(attached_flag),
   .receive_good_flag(receive_good_flag), .ac_track_enable(ac_track_enable),
   .tone_enable(tone_enable), .phy_hard_reset(phy_hard_reset));

// ---- tb/pps_link_master.sv ----
// link-layer side register bus master model
`timescale 1ns/100ps
module pps_link_master
(
   input wire logic aclk, // clock
   output logic [7:0] awaddr = 8'h00, // aw addr
   output logic awvalid = 1'b0, // aw valid
   input wire logic awready, // aw ready
   output logic [31:0] wdata = 32'h0000_0000, // w data
   output logic [3:0] wstrb = 4'h0, // lanes
   output logic wvalid = 1'b0, // w valid
   input wire logic wready, // w ready
   input wire logic [1:0] bresp, // b resp
   input wire logic bvalid, // b valid
   output logic bready = 1'b0, // b ready
   output logic [7:0] araddr = 8'h00, // ar addr
   output logic arvalid = 1'b0, // ar valid
   input wire logic arready, // ar ready
   input wire logic [31:0] rdata, // r data
   input wire logic [1:0] rresp, // r resp
   input wire logic rvalid, // r valid
   output logic rready = 1'b0 // r ready
);
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge aclk); while (!(awready && wready));
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge aclk); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
endmodule // pps_link_master

// ---- tb/tb_pps_regs.sv ----
// self-checking bench for the paged register bank
`timescale 1ns/100ps
module tb_pps_regs
   import pps_pkg::*;
;
   localparam logic [23:0] MK = 24'h00_0a5c; // arbitrary
   localparam logic [23:0] PT = 24'h00_0c3a; // arbitrary
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [12:0] ev = '0;
   logic [2:0] sby = '0, dis = '0, ratt = '0, rrg = '0, att, rg, act, ton;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, seed = 32'h0000_0021;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic hrst, irq;
   int error_cnt = 0, n_tests = 0;
   always #4 aclk = ~aclk;
   pps_link_master lm_u (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   pps_regs #(.NPORTS(3), .MAKER_ID(MK), .PART_ID(PT)) dut_u (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .codeword_error(ev[2:0]), .remote_error_read(ev[5:3]), .loop_disable_enter(ev[8:6]),
      .port_disconnect(ev[11:9]), .bus_reset(ev[12]), .port_in_standby(sby),
      .port_disabled(dis), .raw_attached(ratt), .raw_receive_good(rrg), .attached_flag(att),
      .receive_good_flag(rg), .ac_track_enable(act), .tone_enable(ton),
      .phy_hard_reset(hrst), .irq(irq));
   // ==========================================================
   // helpers
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [31:0] exp_pg(input logic [2:0] pg, input int i);
      logic [47:0] id;
      id = {MK, PT};
      if (pg == PAGE_IDENT && i == 8) return 32'(COMPLIANCE_VALUE);
      if (pg == PAGE_IDENT && i >= 10) return 32'(id[8*(15-i) +: 8]);
      return 32'h0000_0000;
   endfunction
   function automatic logic [31:0] exp_pw(input int c, input logic lp, sb, dp);
      return {21'h0, dp, sb, lp, (c > 255) ? 8'hff : 8'(c)};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, s);
      n_tests++;
      if (s !== e)
      begin
         $display("mismatch %s expected %h seen %h", nm, e, s);
         error_cnt++;
      end
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      lm_u.rd(a, d, r);
      chk(nm, e, d);
      chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      lm_u.wr(a, d, r);
      chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
   endtask
   task automatic pulse(input logic [12:0] v);
      @(posedge aclk);
      ev <= v;
      @(posedge aclk);
      ev <= '0;
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      #100_000;
      error_cnt++;
      tally_and_finish();
   end
   // ==========================================================
   // tests
   initial
   begin
      int n[3];
      logic [31:0] d;
      logic [1:0] r;
      logic [2:0] pgs[3];
      pgs = '{PAGE_RESET, PAGE_IDENT, PAGE_MAKER};
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      for (int k = 0; k < 3; k++)
      begin
         wr(8'h1c, 32'(pgs[k]));
         for (int i = 8; i < 16; i++)
            rchk("paged", 8'(4*i), exp_pg(pgs[k], i));
      end
      wr(8'h1c, 32'(PAGE_IDENT));
      wr(8'h20, 32'h0000_00ff);
      rchk("ro compliance", 8'h20, 32'(COMPLIANCE_VALUE));
      lm_u.rd(8'hfc, d, r);
      chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
      $display("test pages finished");
      n[0] = rnd() % 40;
      n[1] = rnd() % 40 + 1;
      n[2] = 300;
      for (int k = 0; k < 300; k++)
         pulse({10'h000, k < n[2], k < n[1], k < n[0]});
      chk("irq masked", 32'h0, {31'h0, irq});
      rchk("irq status", 8'h50, 32'h0000_0004);
      wr(8'h54, 32'h0000_0004);
      chk("irq on", 32'h1, {31'h0, irq});
      for (int p = 0; p < 3; p++)
         rchk("count", 8'(64+4*p), exp_pw(n[p], 0, 0, 0));
      for (int p = 0; p < 3; p++)
         rchk("cleared", 8'(64+4*p), 32'h0);
      wr(8'h58, 32'h0000_0004);
      chk("irq off", 32'h0, {31'h0, irq});
      pulse(13'h0002);
      pulse(13'h0010);
      rchk("remote", 8'h44, 32'h0);
      $display("test counters finished");
      sby <= 3'(rnd());
      pulse(13'h01c0);
      for (int p = 0; p < 3; p++)
         rchk("loop set", 8'(64+4*p), exp_pw(0, 1, sby[p], 0));
      pulse(13'h1000);
      pulse(13'h0180);
      pulse(13'h0400);
      for (int p = 0; p < 3; p++)
         rchk("loop clr", 8'(64+4*p), exp_pw(0, p == 2, sby[p], 0));
      rchk("irq loop", 8'h50, 32'h0000_0038);
      $display("test loop finished");
      ratt <= 3'h7;
      rrg <= 3'h7;
      dis <= 3'h6;
      wr(8'h40, 32'h0000_0400);
      chk("tone idle", 32'h7, {29'h0, ton});
      dis <= 3'h7;
      @(posedge aclk);
      chk("attached", 32'h6, {29'h0, att});
      chk("rx good", 32'h6, {29'h0, rg});
      chk("tones", 32'h6, {29'h0, ton});
      chk("ac track", 32'h6, {29'h0, act});
      rchk("deep", 8'h40, exp_pw(0, 0, sby[0], 1));
      $display("test shutoff finished");
      wr(8'h1c, 32'h0000_0007);
      wr(8'h38, 32'h0000_0001);
      chk("hard", 32'h1, {31'h0, hrst});
      repeat (12) @(posedge aclk);
      chk("hard end", 32'h0, {31'h0, hrst});
      rchk("page", 8'h1c, 32'h0);
      rchk("deep off", 8'h40, exp_pw(0, 0, sby[0], 0));
      chk("tone back", 32'h7, {29'h0, ton});
      rchk("irq st reset", 8'h50, 32'h0);
      rchk("irq en reset", 8'h54, 32'h0);
      $display("test soft reset finished");
      tally_and_finish();
   end
endmodule // tb_pps_regs
